// File: rtl/serial_eeprom_consts.svh
// constants for the two-wire serial memory slave: codes, fields and timing
`ifndef SERIAL_EEPROM_CONSTS_SVH
`define SERIAL_EEPROM_CONSTS_SVH

// control byte layout
`define CTRL_TYPE_CODE      4'ha
`define CTRL_TYPE_MSB       7
`define CTRL_TYPE_LSB       4
`define CTRL_SEL_MSB        3
`define CTRL_SEL_LSB        1
`define CTRL_RW_BIT         0
`define CTRL_RW_READ        1'h1

// memory array
`define ADDR_BITS           15
`define DATA_BITS           8
`define ADDR_HIGH_USED_MSB  6
`define PAGE_BITS           6
`define ADDR_RESET          15'h0000

// serial byte framing
`define BIT_COUNT_LAST      4'h7
`define BIT_COUNT_FULL      4'h8

// timing
`define CLK_PERIOD_PS       5000
`define WRITE_CYCLE_NS      5000000
// worked in whole nanoseconds so the product cannot overflow 32 bits
`define WRITE_CYCLES        ((`WRITE_CYCLE_NS + `CLK_PERIOD_PS / 1000 - 1) / (`CLK_PERIOD_PS / 1000))

// fifo shape
`define WRQ_DEPTH           4

`endif

// File: rtl/serial_eeprom_pkg.sv
// types shared by the two-wire serial memory slave and its write queue
package serial_eeprom_pkg;

	// one byte waiting to be committed by the write cycle
	typedef struct packed {
		logic [14:0] addr;
		logic [7:0]  data;
	} wr_entry_t;

	// bit-level phase of the slave on the bus
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_RECV,
		PH_ACK,
		PH_SEND,
		PH_MACK,
		PH_IGNORE
	} phase_t;

	// which byte of a command is being received
	typedef enum logic [1:0] {
		BK_CTRL,
		BK_ADDRH,
		BK_ADDRL,
		BK_DATA
	} byte_kind_t;

endpackage : serial_eeprom_pkg

// File: rtl/byte_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 23,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             wrValid,
	output logic                  wrReady,
	input  wire logic [WIDTH-1:0] wrData,
	// drain side
	output logic                  rdValid,
	input  wire logic             rdReady,
	output logic [WIDTH-1:0]      rdData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	assign wrReady = (count != PW'(0) + (PW+1)'(DEPTH));
	assign rdValid = (count != '0);
	assign rdData  = store[rdPtr];
	assign push    = wrValid && wrReady;
	assign pop     = rdValid && rdReady;

	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr] <= wrData;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
			end
			if (pop) begin
				rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
			end
			if (push && !pop) begin
				count <= count + (PW+1)'(1);
			end else if (pop && !push) begin
				count <= count - (PW+1)'(1);
			end
		end
	end

endmodule : byte_fifo

// File: rtl/serial_eeprom_slave.sv
// two-wire serial memory slave: ack polling, current, random and sequential reads
//
// What this block does
// - Control bytes get no acknowledge while an internal write cycle runs.
// - Internal write cycle starts on the Stop ending a write command.
// - After the write cycle ends the polling control byte is acknowledged.
// - Read/write bit one selects a read; otherwise formed like a write.
// - Pointer holds last accessed address plus one for current address reads.
// - Matching read control byte is acknowledged, then one byte shifts out.
// - Unacknowledged read byte plus Stop ends transmission.
// - Repeated Start ends the command; bytes already queued are written after the next Stop; loaded address kept.
// - After a random read the pointer points past the byte read.
// - Each master acknowledge during a read sends the next byte.
// - Pointer increments by one after every byte read, and within its page after every byte written.
// - Pointer wraps from the top address to zero on sequential reads.
// - Respond only to type code 1010 and matching chip-select bits.
// - Address is two bytes, high first; only fifteen low bits used.
// - Data line released after a read byte the master leaves unacknowledged.
`timescale 1ns/1ps
`include "serial_eeprom_consts.svh"
module serial_eeprom_slave #(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
	parameter int          QUEUE_DEPTH  = `WRQ_DEPTH
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// two-wire bus, open drain data
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	// device select straps
	input  wire logic [2:0] chipSelectPins,
	// status
	output logic            writeBusy
);
	import serial_eeprom_pkg::*;

	localparam int TW = $clog2(WRITE_CYCLES + 1);
	localparam int EW = $bits(serial_eeprom_pkg::wr_entry_t);

	// memory array
	logic [`DATA_BITS-1:0] mem [2**`ADDR_BITS];

	// input synchronisers
	logic       sclMeta;
	logic       sclSync;
	logic       sdaMeta;
	logic       sdaSync;
	logic [2:0] csMeta;
	logic [2:0] csSync;
	logic       sclPrev;
	logic       sdaPrev;

	// bus edges and conditions
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;

	// byte engine
	phase_t                phase;
	byte_kind_t            kind;
	logic [3:0]            bitCnt;
	logic [7:0]            rxShift;
	logic [7:0]            txShift;
	logic [`ADDR_BITS-1:0] pointer;
	logic [7:0]            addrHigh;
	logic                  readMode;
	logic                  masterAck;
	logic                  pendingWrite;

	// write queue and write cycle
	wr_entry_t             qIn;
	wr_entry_t             qOut;
	logic                  qWrValid;
	logic                  qWrReady;
	logic                  qRdValid;
	logic                  qRdReady;
	logic [TW-1:0]         wcTimer;

	// decoded received byte
	logic [7:0]            rxByte;
	logic                  ctrlMatch;
	logic                  ctrlRead;

	// two flops before anything looks at a pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclMeta <= 1'h1;
			sclSync <= 1'h1;
			sdaMeta <= 1'h1;
			sdaSync <= 1'h1;
			csMeta  <= 3'h0;
			csSync  <= 3'h0;
			sclPrev <= 1'h1;
			sdaPrev <= 1'h1;
		end else begin
			sclMeta <= sclIn;
			sclSync <= sclMeta;
			sdaMeta <= sdaIn;
			sdaSync <= sdaMeta;
			csMeta  <= chipSelectPins;
			csSync  <= csMeta;
			sclPrev <= sclSync;
			sdaPrev <= sdaSync;
		end
	end

	assign sclRise   = sclSync && !sclPrev;
	assign sclFall   = !sclSync && sclPrev;
	assign startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
	assign stopCond  = sclSync && sclPrev && !sdaPrev && sdaSync;

	// all eight bits are in rxShift by the fall after the eighth rising edge, so decode it as is
	assign rxByte    = rxShift;
	assign ctrlMatch = (rxByte[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] == `CTRL_TYPE_CODE)
	                && (rxByte[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == csSync);
	assign ctrlRead  = (rxByte[`CTRL_RW_BIT] == `CTRL_RW_READ);

	assign qIn.addr  = pointer;
	assign qIn.data  = rxByte;
	assign qWrValid  = (phase == PH_RECV) && sclFall && (bitCnt == `BIT_COUNT_FULL)
	                && (kind == BK_DATA) && qWrReady;
	// the queue only drains while the write cycle is running
	assign qRdReady  = writeBusy;

	byte_fifo #(
		.WIDTH (EW),
		.DEPTH (QUEUE_DEPTH)
	) u_write_queue (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wrValid (qWrValid),
		.wrReady (qWrReady),
		.wrData  (qIn),
		.rdValid (qRdValid),
		.rdReady (qRdReady),
		.rdData  (qOut)
	);

	// commit queued bytes during the write cycle
	always_ff @(posedge clk) begin
		if (qRdValid && qRdReady) begin
			mem[qOut.addr] <= qOut.data;
		end
	end

	// write cycle timer: starts on the stop of a write, ends when time and queue are done
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			writeBusy <= 1'h0;
			wcTimer   <= '0;
		end else if (!writeBusy) begin
			if (stopCond && pendingWrite) begin
				writeBusy <= 1'h1;
				wcTimer   <= TW'(WRITE_CYCLES);
			end
		end else if (wcTimer != '0) begin
			wcTimer <= wcTimer - TW'(1);
		end else if (!qRdValid) begin
			writeBusy <= 1'h0;
		end
	end

	// byte engine: receive, acknowledge, transmit, sample master acknowledge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase        <= PH_IDLE;
			kind         <= BK_CTRL;
			bitCnt       <= 4'h0;
			rxShift      <= 8'h00;
			txShift      <= 8'h00;
			readMode     <= 1'h0;
			masterAck    <= 1'h0;
			addrHigh     <= 8'h00;
			pendingWrite <= 1'h0;
			sdaOe        <= 1'h0;
		end else if (startCond) begin
			// a repeated start ends a write; pendingWrite stays set, so queued bytes are committed at the next stop
			phase    <= PH_RECV;
			kind     <= BK_CTRL;
			bitCnt   <= 4'h0;
			readMode <= 1'h0;
			sdaOe    <= 1'h0;
		end else if (stopCond) begin
			phase        <= PH_IDLE;
			pendingWrite <= 1'h0;
			sdaOe        <= 1'h0;
		end else begin
			case (phase)
				PH_RECV: begin
					if (sclRise && bitCnt != `BIT_COUNT_FULL) begin
						rxShift <= {rxShift[6:0], sdaSync};
						bitCnt  <= bitCnt + 4'h1;
					end else if (sclFall && bitCnt == `BIT_COUNT_FULL) begin
						case (kind)
							BK_CTRL: begin
								if (ctrlMatch && !writeBusy) begin
									phase    <= PH_ACK;
									sdaOe    <= 1'h1;
									readMode <= ctrlRead;
									kind     <= BK_ADDRH;
								end else begin
									phase <= PH_IGNORE;
								end
							end
							BK_ADDRH: begin
								addrHigh <= rxByte;
								kind     <= BK_ADDRL;
								phase    <= PH_ACK;
								sdaOe    <= 1'h1;
							end
							BK_ADDRL: begin
								kind  <= BK_DATA;
								phase <= PH_ACK;
								sdaOe <= 1'h1;
							end
							default: begin
								// a full queue refuses the byte instead of dropping it
								if (qWrReady) begin
									pendingWrite <= 1'h1;
									phase        <= PH_ACK;
									sdaOe        <= 1'h1;
								end else begin
									phase <= PH_IGNORE;
								end
							end
						endcase
					end
				end
				PH_ACK: begin
					if (sclFall) begin
						bitCnt <= 4'h0;
						if (readMode) begin
							txShift <= {mem[pointer][6:0], 1'h0};
							sdaOe   <= !mem[pointer][7];
							phase   <= PH_SEND;
						end else begin
							sdaOe <= 1'h0;
							phase <= PH_RECV;
						end
					end
				end
				PH_SEND: begin
					if (sclFall) begin
						if (bitCnt == `BIT_COUNT_LAST) begin
							sdaOe  <= 1'h0;
							bitCnt <= 4'h0;
							phase  <= PH_MACK;
						end else begin
							sdaOe   <= !txShift[7];
							txShift <= {txShift[6:0], 1'h0};
							bitCnt  <= bitCnt + 4'h1;
						end
					end
				end
				PH_MACK: begin
					if (sclRise) begin
						masterAck <= !sdaSync;
					end else if (sclFall) begin
						if (masterAck) begin
							txShift <= {mem[pointer][6:0], 1'h0};
							sdaOe   <= !mem[pointer][7];
							phase   <= PH_SEND;
						end else begin
							sdaOe <= 1'h0;
							phase <= PH_IGNORE;
						end
					end
				end
				default: begin
					sdaOe <= 1'h0;
				end
			endcase
		end
	end

	// address pointer: loaded by the address bytes, stepped after each byte
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pointer <= `ADDR_RESET;
		end else if (!startCond && !stopCond) begin
			if (phase == PH_RECV && sclFall && bitCnt == `BIT_COUNT_FULL
			    && kind == BK_ADDRL) begin
				pointer <= {addrHigh[`ADDR_HIGH_USED_MSB:0], rxByte};
			end else if (qWrValid) begin
				// writes stay inside their page
				pointer <= {pointer[`ADDR_BITS-1:`PAGE_BITS],
				            pointer[`PAGE_BITS-1:0] + `PAGE_BITS'(1)};
			end else if (sclFall && readMode
			             && (phase == PH_ACK || (phase == PH_MACK && masterAck))) begin
				// top address wraps to zero by width
				pointer <= pointer + `ADDR_BITS'(1);
			end
		end
	end

	// open drain: the pin is only ever pulled low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sdaOut <= 1'h0;
		end else begin
			sdaOut <= 1'h0;
		end
	end

endmodule : serial_eeprom_slave

// File: sim/serial_eeprom_slave_sva.sv
// port checker for the two-wire serial memory slave, bound to its top module
`timescale 1ns/1ps
module serial_eeprom_slave_sva #(
	parameter int unsigned WRITE_CYCLES = 200
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// bus pins and status
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic [2:0] chipSelectPins,
	input wire logic       writeBusy
);
	logic sclQ;
	logic sdaQ;
	int   busyCnt;
	int   stopAge;
	int   fallAge;
	int   highCnt;
	// ages saturate so long idle stretches cannot wrap them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			busyCnt <= 0;
			stopAge <= 99;
			fallAge <= 99;
			highCnt <= 0;
		end else begin
			sclQ <= sclIn;
			sdaQ <= sdaIn;
			busyCnt <= writeBusy ? busyCnt + 1 : 0;
			stopAge <= (sclQ && sclIn && !sdaQ && sdaIn) ? 0 : (stopAge < 99 ? stopAge + 1 : 99);
			fallAge <= (sclQ && !sclIn) ? 0 : (fallAge < 99 ? fallAge + 1 : 99);
			highCnt <= sclIn ? (highCnt < 99 ? highCnt + 1 : 99) : 0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_open_drain;
		sdaOut == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data driven high");
	property p_busy_no_ack;
		writeBusy |-> !sdaOe;
	endproperty
	a_busy_no_ack: assert property (p_busy_no_ack) else $error("ack while busy");
	property p_busy_len;
		$fell(writeBusy) |-> busyCnt >= int'(WRITE_CYCLES);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle too short");
	property p_busy_after_stop;
		$rose(writeBusy) |-> stopAge <= 8;
	endproperty
	a_busy_after_stop: assert property (p_busy_after_stop) else $error("busy without stop");
	property p_oe_after_fall;
		$changed(sdaOe) |-> fallAge <= 8;
	endproperty
	a_oe_after_fall: assert property (p_oe_after_fall) else $error("data moved off clock fall");
	property p_oe_stable_high;
		highCnt >= 2 |-> $stable(sdaOe);
	endproperty
	a_oe_stable_high: assert property (p_oe_stable_high) else $error("data moved in high phase");
	property p_stop_release;
		stopAge <= 10 |-> !sdaOe;
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("drive after stop");
	property p_reset_idle;
		$fell(sys_rst) |-> !sdaOe && !writeBusy;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule : serial_eeprom_slave_sva
bind serial_eeprom_slave serial_eeprom_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
	.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .chipSelectPins(chipSelectPins), .writeBusy(writeBusy));

// File: sim/eeprom_bus_master.sv
// two-wire bus master model: 125 ns clock, data moved 30 ns after each fall
`timescale 1ns/1ps
module eeprom_bus_master (
	// bus pins
	output logic     scl,
	output logic     sdaLow,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic bitCyc(input logic drive, output logic seen);
		sdaLow = !drive;
		#30 scl = 1'b1;
		#35 seen = sda;
		#30 scl = 1'b0;
		#30;
	endtask : bitCyc
	task automatic start;
		sdaLow = 1'b0;
		#30 scl = 1'b1;
		#35 sdaLow = 1'b1;
		#60 scl = 1'b0;
		#30;
	endtask : start
	task automatic stop;
		sdaLow = 1'b1;
		#30 scl = 1'b1;
		#35 sdaLow = 1'b0;
		#60;
	endtask : stop
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCyc(b[i], s);
		end
		bitCyc(1'b1, s);
		ack = !s;
	endtask : sendByte
	task automatic readByte(input logic ackIt, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCyc(1'b1, b[i]);
		end
		bitCyc(!ackIt, s);
	endtask : readByte
endmodule : eeprom_bus_master

// File: sim/test_serial_eeprom_read_and_ack_poll.sv
// self-checking bench: writes, busy polling and the three read kinds against a model
`timescale 1ns/1ps
module test_serial_eeprom_read_and_ack_poll;
	localparam int unsigned WCYC = 400;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [2:0]  cs;
	logic        scl;
	logic        sdaLow;
	logic        sdaOut;
	logic        sdaOe;
	logic        writeBusy;
	wire         sda = !(sdaLow || sdaOe);
	int          num_errors = 0;
	int          checked = 0;
	logic [7:0]  mem [logic [14:0]];
	logic [14:0] ptr = 15'h0000;
	logic [3:0]  badKind;
	always #2.5 clk = ~clk;
	eeprom_bus_master i_master (.scl(scl), .sdaLow(sdaLow), .sda(sda));
	serial_eeprom_slave #(.WRITE_CYCLES(WCYC)) i_dut (.clk(clk), .sys_rst(sys_rst), .sclIn(scl),
		.sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectPins(cs), .writeBusy(writeBusy));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic results;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	task automatic ctl(input logic [3:0] kind, input logic [2:0] sel, input logic rw, input logic expAck);
		logic a;
		i_master.start();
		i_master.sendByte({kind, sel, rw}, a);
		chk({7'h0, a}, {7'h0, expAck});
	endtask : ctl
	task automatic setAddr(input logic [14:0] a);
		logic k;
		ctl(4'ha, cs, 1'b0, 1'b1);
		i_master.sendByte({1'($urandom), a[14:8]}, k);
		chk({7'h0, k}, 8'h01);
		i_master.sendByte(a[7:0], k);
		chk({7'h0, k}, 8'h01);
		ptr = a;
	endtask : setAddr
	task automatic wr(input logic [14:0] a, input int n);
		logic [7:0] d;
		logic       k;
		int         nacks;
		setAddr(a);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			i_master.sendByte(d, k);
			// a fifth byte finds the four-entry queue full and is refused
			chk({7'h0, k}, {7'h0, i < 4});
			if (i < 4) begin
				mem[ptr] = d;
				ptr[5:0] = ptr[5:0] + 6'h01;
			end
		end
		i_master.stop();
		repeat (10) @(negedge clk);
		chk({7'h0, writeBusy}, 8'h01);
		nacks = 0;
		k = 1'b0;
		while (!k && nacks < 40) begin
			i_master.start();
			i_master.sendByte({4'ha, cs, 1'b0}, k);
			nacks += int'(!k);
		end
		if (!k) begin
			num_errors++;
			results();
		end
		chk({7'h0, nacks > 0}, 8'h01);
		i_master.stop();
	endtask : wr
	task automatic rd(input int n);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			i_master.readByte(i < n - 1, b);
			chk(b, mem[ptr]);
			ptr = ptr + 15'h0001;
		end
		i_master.stop();
	endtask : rd
	initial begin
		void'($urandom(32'h7ff9));
		cs = 3'($urandom);
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge clk);
		chk({7'h0, writeBusy}, 8'h00);
		wr(15'h0000, 5);
		wr(15'h7ffc, 4);
		// sequential read across the top of the array
		setAddr(15'h7ffe);
		ctl(4'ha, cs, 1'b1, 1'b1);
		rd(3);
		ctl(4'ha, cs, 1'b1, 1'b1);
		rd(1);
		ctl(4'ha, cs ^ 3'($urandom_range(7, 1)), 1'b1, 1'b0);
		i_master.stop();
		badKind = 4'ha ^ 4'($urandom_range(15, 1));
		ctl(badKind, cs, 1'b0, 1'b0);
		i_master.stop();
		setAddr(15'h7ffd);
		ctl(4'ha, cs, 1'b1, 1'b1);
		rd(1);
		ctl(4'ha, cs, 1'b1, 1'b1);
		rd(4);
		results();
	end
endmodule : test_serial_eeprom_read_and_ack_poll
